//--- pkg/bmd_defs.svh
`ifndef BMD_DEFS_SVH
`define BMD_DEFS_SVH

// ----------------------------------------------------------------------
// address map: base and match mask per area
// ----------------------------------------------------------------------
`define BMD_PROM_BASE 32'h00000000
`define BMD_PROM_MASK 32'hFFF80000
`define BMD_REGS_BASE 32'h01F80000
`define BMD_REGS_MASK 32'hFFF80000
`define BMD_RAM_BASE 32'h02000000
`define BMD_RAM_MASK 32'hFFE00000
`define BMD_RAMX_BASE 32'h02200000
`define BMD_RAMX_MASK 32'hFFE00000
`define BMD_IO0_BASE 32'h10000000
`define BMD_IO0_MASK 32'hFFFFFE00

// ----------------------------------------------------------------------
// access sizes and chip select positions
// ----------------------------------------------------------------------
`define BMD_SZ_BYTE 2'h0
`define BMD_SZ_HALF 2'h1
`define BMD_SZ_WORD 2'h2
`define BMD_CS_BANK0 0
`define BMD_CS_BANK1 1
`define BMD_CS_REDUND 8
`define BMD_CS_NONE 9'h1FF

// ----------------------------------------------------------------------
// boot wait-state settings
// ----------------------------------------------------------------------
`define BMD_BOOT_RAM_RD_WS 0
`define BMD_BOOT_RAM_WR_WS 0
`define BMD_BOOT_PROM_WS 1
`define BMD_BOOT_IO0_WS 1

`endif

//--- pkg/bmd_pkg.sv
package bmd_pkg;

	// access sequencer states
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01,
		ST_PROM = 2'b10,
		ST_ANS = 2'b11
	} bmd_state_t;

	// decoded address areas
	typedef enum logic [2:0] {
		AR_NONE = 3'b000,
		AR_PROM = 3'b001,
		AR_REGS = 3'b010,
		AR_RAM = 3'b011,
		AR_RAMX = 3'b100,
		AR_IO0 = 3'b101
	} bmd_area_t;

endpackage : bmd_pkg

//--- hdl/bmd_board_decode.sv
// Contract
// R1: nominal 2 MB RAM bank on select 0 at 0x02000000, one contiguous region.
// R2: RAM accesses run with no wait states when RAM setting is zero.
// R3: two 2 MB banks on selects 0 and 1, redundant bank on select 8.
// R4: boot PROM is byte wide, one wait state per byte access.
// R5: PROM at 0x00000000 over 512k, words from bytes, no parity, byte writes.
// R6: register window at 0x01F80000, parity only, word writes, any read size.
// R7: expansion RAM at 0x02200000 over 2M, parity or EDAC, all sizes.
// R8: I/O area 0 at 0x10000000, 512 bytes, optional parity, all sizes.
// R9: unimplemented area access answers with a memory exception.
// R10: boot wait states: RAM 0 read and write, PROM 1, I/O 0 one.
// R11: external halt freezes processor units and this logic.
// R12: availability flag cleared by reset, set only by software write.
// R13: availability output forced low while processor halted.
// R14: error output asserted on any unmasked unit or own error.
// R15: unmasked error halts processor unless reset mode programmed.
// R16: halted output from external halt, software halt or error halt.
// R17: after hardware reset fetch starts in boot PROM region.
// R18: PROM byte at lowest address lands in most significant lane.
`include "bmd_defs.svh"

module bmd_board_decode #(
	parameter int WS_W = 4
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic resetn_i,
	// processor bus request
	input wire logic req_i,
	input wire logic [31:0] addr_i,
	input wire logic write_i,
	input wire logic [1:0] size_i,
	input wire logic [31:0] wdata_i,
	// processor bus answer
	output logic ready_o,
	output logic mexc_o,
	output logic [31:0] rdata_o,
	output logic [31:0] boot_vector_o,
	// memory side
	output logic [8:0] memory_bank_select_n_o,
	output logic prom_sel_n_o,
	output logic regs_sel_n_o,
	output logic io0_sel_n_o,
	output logic [31:0] mem_addr_o,
	output logic mem_rd_o,
	output logic mem_wr_o,
	output logic [1:0] mem_size_o,
	output logic [31:0] mem_wdata_o,
	output logic par_chk_o,
	output logic edac_chk_o,
	input wire logic [31:0] mem_rdata_i,
	// configuration
	input wire logic ramx_present_i,
	input wire logic io0_present_i,
	input wire logic redund_sel_i,
	input wire logic ram_edac_i,
	input wire logic io0_parity_i,
	input wire logic ws_cfg_wr_i,
	input wire logic [WS_W-1:0] ram_rd_ws_i,
	input wire logic [WS_W-1:0] ram_wr_ws_i,
	input wire logic [WS_W-1:0] prom_ws_i,
	input wire logic [WS_W-1:0] io0_ws_i,
	// halt and error
	input wire logic external_halt_request_i,
	input wire logic sw_halt_i,
	input wire logic system_available_out_set_i,
	input wire logic integer_unit_err_i,
	input wire logic floating_point_unit_err_i,
	input wire logic own_err_i,
	input wire logic [2:0] err_mask_i,
	input wire logic err_reset_mode_i,
	output logic freeze_o,
	output logic error_reset_o,
	output logic system_available_out_o,
	output logic system_error_out_o,
	output logic processor_halted_out_o
);

	// ------------------------------------------------------------------
	// elaboration check
	// ------------------------------------------------------------------
	if (WS_W < 1 || WS_W > 8) begin : g_chk
		$error("WS_W must lie in 1..8");
	end

	// ------------------------------------------------------------------
	// halt input synchroniser and wait-state configuration
	// ------------------------------------------------------------------
	logic hsync1_r, hsync2_r;
	logic [WS_W-1:0] ram_rd_ws_r, ram_wr_ws_r, prom_ws_r, io0_ws_r;
	logic [WS_W-1:0] ram_rd_ws_nxt, ram_wr_ws_nxt, prom_ws_nxt, io0_ws_nxt;
	logic frz;

	assign frz = hsync2_r;
	assign freeze_o = hsync2_r; // R11

	// config loads only on the software strobe
	always_comb begin
		ram_rd_ws_nxt = ram_rd_ws_r;
		ram_wr_ws_nxt = ram_wr_ws_r;
		prom_ws_nxt = prom_ws_r;
		io0_ws_nxt = io0_ws_r;
		if (ws_cfg_wr_i) begin
			ram_rd_ws_nxt = ram_rd_ws_i;
			ram_wr_ws_nxt = ram_wr_ws_i;
			prom_ws_nxt = prom_ws_i;
			io0_ws_nxt = io0_ws_i;
		end
	end

	// boot values at reset
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hsync1_r <= 1'b0;
			hsync2_r <= 1'b0;
			ram_rd_ws_r <= WS_W'(`BMD_BOOT_RAM_RD_WS); // R10
			ram_wr_ws_r <= WS_W'(`BMD_BOOT_RAM_WR_WS); // R10
			prom_ws_r <= WS_W'(`BMD_BOOT_PROM_WS); // R4 R10
			io0_ws_r <= WS_W'(`BMD_BOOT_IO0_WS); // R10
		end else begin
			hsync1_r <= external_halt_request_i;
			hsync2_r <= hsync1_r;
			ram_rd_ws_r <= ram_rd_ws_nxt;
			ram_wr_ws_r <= ram_wr_ws_nxt;
			prom_ws_r <= prom_ws_nxt;
			io0_ws_r <= io0_ws_nxt;
		end
	end

	// ------------------------------------------------------------------
	// address decode
	// ------------------------------------------------------------------
	function automatic bmd_pkg::bmd_area_t decode(input logic [31:0] a);
		bmd_pkg::bmd_area_t ar;
		ar = bmd_pkg::AR_NONE; // R9
		if ((a & `BMD_PROM_MASK) == `BMD_PROM_BASE) ar = bmd_pkg::AR_PROM; // R5
		if ((a & `BMD_REGS_MASK) == `BMD_REGS_BASE) ar = bmd_pkg::AR_REGS; // R6
		if ((a & `BMD_RAM_MASK) == `BMD_RAM_BASE) ar = bmd_pkg::AR_RAM; // R1
		if ((a & `BMD_RAMX_MASK) == `BMD_RAMX_BASE && ramx_present_i) begin
			ar = bmd_pkg::AR_RAMX; // R7
		end
		if ((a & `BMD_IO0_MASK) == `BMD_IO0_BASE && io0_present_i) begin
			ar = bmd_pkg::AR_IO0; // R8
		end
		return ar;
	endfunction : decode

	bmd_pkg::bmd_area_t req_area;
	logic misaligned, bad_size;

	always_comb req_area = decode(addr_i); // presence inputs must re-run the decode too
	assign misaligned = (size_i == `BMD_SZ_HALF && addr_i[0]) ||
		(size_i == `BMD_SZ_WORD && addr_i[1:0] != 2'h0) || size_i > `BMD_SZ_WORD;
	// write size limits per area
	assign bad_size = write_i &&
		((req_area == bmd_pkg::AR_PROM && size_i != `BMD_SZ_BYTE) || // R5
		(req_area == bmd_pkg::AR_REGS && size_i != `BMD_SZ_WORD)); // R6

	// ------------------------------------------------------------------
	// access sequencer
	// ------------------------------------------------------------------
	bmd_pkg::bmd_state_t st_r, st_nxt;
	bmd_pkg::bmd_area_t area_r, area_nxt;
	logic err_r, err_nxt, wr_r, wr_nxt, rd_r, rd_nxt, par_r, par_nxt, edac_r, edac_nxt;
	logic [WS_W-1:0] cnt_r, cnt_nxt;
	logic [1:0] left_r, left_nxt, size_r, size_nxt;
	logic [31:0] addr_r, addr_nxt, wdata_r, wdata_nxt, rdata_r, rdata_nxt;
	logic [8:0] bank_n_r, bank_n_nxt;
	logic prom_n_r, prom_n_nxt, regs_n_r, regs_n_nxt, io0_n_r, io0_n_nxt;

	// next access state; whole sequencer holds while frozen
	always_comb begin
		st_nxt = st_r;
		area_nxt = area_r;
		err_nxt = err_r;
		wr_nxt = wr_r;
		rd_nxt = rd_r;
		par_nxt = par_r;
		edac_nxt = edac_r;
		cnt_nxt = cnt_r;
		left_nxt = left_r;
		size_nxt = size_r;
		addr_nxt = addr_r;
		wdata_nxt = wdata_r;
		rdata_nxt = rdata_r;
		bank_n_nxt = bank_n_r;
		prom_n_nxt = prom_n_r;
		regs_n_nxt = regs_n_r;
		io0_n_nxt = io0_n_r;
		if (!frz) begin // R11
			case (st_r)
				bmd_pkg::ST_IDLE: begin
					if (req_i) begin
						area_nxt = req_area;
						addr_nxt = addr_i;
						size_nxt = size_i;
						wdata_nxt = wdata_i;
						err_nxt = 1'b0;
						rdata_nxt = 32'h0;
						if (req_area == bmd_pkg::AR_NONE || misaligned || bad_size) begin
							err_nxt = 1'b1; // R9
							st_nxt = bmd_pkg::ST_ANS;
						end else begin
							wr_nxt = write_i;
							rd_nxt = !write_i;
							st_nxt = bmd_pkg::ST_WAIT;
							case (req_area)
								bmd_pkg::AR_PROM: begin
									prom_n_nxt = 1'b0;
									par_nxt = 1'b0; // R5
									cnt_nxt = prom_ws_r; // R4
									left_nxt = size_i == `BMD_SZ_WORD ? 2'h3 :
										(size_i == `BMD_SZ_HALF ? 2'h1 : 2'h0);
									size_nxt = `BMD_SZ_BYTE;
									if (!write_i) st_nxt = bmd_pkg::ST_PROM; // R5
								end
								bmd_pkg::AR_REGS: begin
									regs_n_nxt = 1'b0;
									par_nxt = 1'b1; // R6
									cnt_nxt = '0;
								end
								bmd_pkg::AR_RAM, bmd_pkg::AR_RAMX: begin
									if (req_area == bmd_pkg::AR_RAMX) begin
										bank_n_nxt[`BMD_CS_BANK1] = 1'b0; // R3 R7
									end else if (redund_sel_i) begin
										bank_n_nxt[`BMD_CS_REDUND] = 1'b0; // R3
									end else begin
										bank_n_nxt[`BMD_CS_BANK0] = 1'b0; // R1
									end
									par_nxt = !ram_edac_i;
									edac_nxt = ram_edac_i;
									cnt_nxt = write_i ? ram_wr_ws_r : ram_rd_ws_r; // R2
								end
								default: begin
									io0_n_nxt = 1'b0; // R8
									par_nxt = io0_parity_i;
									cnt_nxt = io0_ws_r;
								end
							endcase
						end
					end
				end
				bmd_pkg::ST_WAIT: begin
					if (cnt_r != '0) begin
						cnt_nxt = cnt_r - WS_W'(1);
					end else begin
						if (rd_r) rdata_nxt = mem_rdata_i;
						st_nxt = bmd_pkg::ST_ANS;
					end
				end
				bmd_pkg::ST_PROM: begin
					if (cnt_r != '0) begin
						cnt_nxt = cnt_r - WS_W'(1);
					end else begin
						// lowest address to the top lane
						rdata_nxt[(2'h3 - addr_r[1:0]) * 8 +: 8] = mem_rdata_i[7:0]; // R18
						if (left_r == 2'h0) begin
							st_nxt = bmd_pkg::ST_ANS;
						end else begin
							left_nxt = left_r - 2'h1;
							addr_nxt = addr_r + 32'h1;
							cnt_nxt = prom_ws_r; // R4
						end
					end
				end
				bmd_pkg::ST_ANS: begin
					st_nxt = bmd_pkg::ST_IDLE;
				end
				default: begin
					st_nxt = bmd_pkg::ST_IDLE;
				end
			endcase
			if (st_nxt == bmd_pkg::ST_ANS) begin
				bank_n_nxt = `BMD_CS_NONE;
				prom_n_nxt = 1'b1;
				regs_n_nxt = 1'b1;
				io0_n_nxt = 1'b1;
				wr_nxt = 1'b0;
				rd_nxt = 1'b0;
				par_nxt = 1'b0;
				edac_nxt = 1'b0;
			end
		end
	end

	// sequencer registers
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			st_r <= bmd_pkg::ST_IDLE;
			area_r <= bmd_pkg::AR_NONE;
			err_r <= 1'b0;
			wr_r <= 1'b0;
			rd_r <= 1'b0;
			par_r <= 1'b0;
			edac_r <= 1'b0;
			cnt_r <= '0;
			left_r <= 2'h0;
			size_r <= `BMD_SZ_BYTE;
			addr_r <= 32'h0;
			wdata_r <= 32'h0;
			rdata_r <= 32'h0;
			bank_n_r <= `BMD_CS_NONE;
			prom_n_r <= 1'b1;
			regs_n_r <= 1'b1;
			io0_n_r <= 1'b1;
		end else begin
			st_r <= st_nxt;
			area_r <= area_nxt;
			err_r <= err_nxt;
			wr_r <= wr_nxt;
			rd_r <= rd_nxt;
			par_r <= par_nxt;
			edac_r <= edac_nxt;
			cnt_r <= cnt_nxt;
			left_r <= left_nxt;
			size_r <= size_nxt;
			addr_r <= addr_nxt;
			wdata_r <= wdata_nxt;
			rdata_r <= rdata_nxt;
			bank_n_r <= bank_n_nxt;
			prom_n_r <= prom_n_nxt;
			regs_n_r <= regs_n_nxt;
			io0_n_r <= io0_n_nxt;
		end
	end

	// answer and memory-side outputs
	assign ready_o = st_r == bmd_pkg::ST_ANS && !err_r && !frz;
	assign mexc_o = st_r == bmd_pkg::ST_ANS && err_r && !frz; // R9
	assign rdata_o = rdata_r;
	assign boot_vector_o = `BMD_PROM_BASE; // R17
	assign memory_bank_select_n_o = bank_n_r;
	assign prom_sel_n_o = prom_n_r;
	assign regs_sel_n_o = regs_n_r;
	assign io0_sel_n_o = io0_n_r;
	assign mem_addr_o = addr_r;
	assign mem_rd_o = rd_r;
	assign mem_wr_o = wr_r;
	assign mem_size_o = size_r;
	assign mem_wdata_o = wdata_r;
	assign par_chk_o = par_r;
	assign edac_chk_o = edac_r;

	// ------------------------------------------------------------------
	// halt, error and availability
	// ------------------------------------------------------------------
	logic err_hit, err_halt_r, err_halt_nxt, halted_r, halted_nxt;
	logic system_error_out_r, system_available_out_r, system_available_out_nxt, erst_r;

	assign err_hit = |({integer_unit_err_i, floating_point_unit_err_i, own_err_i} & ~err_mask_i);

	// error halt latches until reset; in reset mode error_reset_o follows the unmasked error one cycle later
	always_comb begin
		err_halt_nxt = err_halt_r | (err_hit & !err_reset_mode_i); // R15
		halted_nxt = frz | sw_halt_i | err_halt_nxt; // R16
		system_available_out_nxt = system_available_out_r | system_available_out_set_i; // R12
	end

	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			err_halt_r <= 1'b0;
			halted_r <= 1'b0;
			system_error_out_r <= 1'b0;
			system_available_out_r <= 1'b0; // R12
			erst_r <= 1'b0;
		end else begin
			err_halt_r <= err_halt_nxt;
			halted_r <= halted_nxt;
			system_error_out_r <= err_hit; // R14
			system_available_out_r <= system_available_out_nxt;
			erst_r <= err_hit & err_reset_mode_i; // R15
		end
	end

	assign processor_halted_out_o = halted_r;
	assign system_error_out_o = system_error_out_r;
	assign error_reset_o = erst_r;
	assign system_available_out_o = system_available_out_r & !halted_r; // R13

	// ------------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!resetn_i);

	a_unmapped_exc: assert property (st_r == bmd_pkg::ST_IDLE && req_i && !frz && // R9
		req_area == bmd_pkg::AR_NONE |=> st_r == bmd_pkg::ST_ANS && err_r)
		else $error("unmapped access not refused");
	a_ram_zero_wait: assert property (st_r == bmd_pkg::ST_IDLE && req_i && !frz && // R2
		req_area == bmd_pkg::AR_RAM && !misaligned && ram_rd_ws_r == '0 && !write_i
		##1 !frz |=> st_r == bmd_pkg::ST_ANS)
		else $error("zero wait RAM read took too long");
	a_bank_select: assert property (st_r == bmd_pkg::ST_WAIT && area_r == bmd_pkg::AR_RAMX // R3
		|-> !bank_n_r[`BMD_CS_BANK1] && bank_n_r[`BMD_CS_BANK0])
		else $error("expansion bank select wrong");
	a_prom_write_size: assert property (st_r == bmd_pkg::ST_IDLE && req_i && !frz && // R5
		req_area == bmd_pkg::AR_PROM && write_i && size_i != `BMD_SZ_BYTE |=> err_r)
		else $error("wide PROM write accepted");
	a_regs_write_word: assert property (st_r == bmd_pkg::ST_IDLE && req_i && !frz && // R6
		req_area == bmd_pkg::AR_REGS && write_i && size_i != `BMD_SZ_WORD |=> err_r)
		else $error("narrow register write accepted");
	a_freeze_hold: assert property (frz |=> $stable(st_r) && $stable(cnt_r)) // R11
		else $error("sequencer moved while frozen");
	a_avail_halt: assert property (processor_halted_out_o |-> !system_available_out_o) // R13
		else $error("available while halted");
	a_avail_set: assert property (!system_available_out_r && !system_available_out_set_i |=> !system_available_out_r) // R12
		else $error("availability set without software");
	a_error_out: assert property (err_hit |=> system_error_out_o) // R14
		else $error("error output missing");
	a_error_halt: assert property (err_hit && !err_reset_mode_i // R15
		|=> processor_halted_out_o [*3])
		else $error("error did not halt");
	a_sw_halt: assert property (sw_halt_i |=> processor_halted_out_o) // R16
		else $error("software halt not shown");

	c_prom_word: cover property (st_r == bmd_pkg::ST_PROM && left_r == 2'h3 ##[1:40] ready_o);
	c_ram_read: cover property (st_r == bmd_pkg::ST_WAIT && area_r == bmd_pkg::AR_RAM
		##1 ready_o);
	c_exception: cover property (mexc_o);
	c_error_halt: cover property (err_hit && !err_reset_mode_i ##1 processor_halted_out_o);

endmodule : bmd_board_decode

//--- tb/bmd_mem_model.sv
// ----------------------------------------
// memory and register side stand-in
// ----------------------------------------
module bmd_mem_model (
	// clock
	input wire logic clk_i,
	// memory strobe side
	input wire logic mem_rd_i,
	input wire logic [31:0] mem_addr_i,
	output logic [31:0] mem_rdata_o
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [31:0] last_r = 32'h0;
	// data is the scrambled address; an idle bus flips every cycle so stale data never passes
	assign mem_rdata_o = mem_rd_i ? (mem_addr_i ^ 32'h5A5A5A5A) : ~last_r;
	// remember what was last on the bus
	always @(posedge clk_i) begin
		last_r <= mem_rdata_o;
	end
endmodule : bmd_mem_model

//--- tb/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	typedef struct {logic mx; logic ck; logic [31:0] rd; int lat;} bmd_exp_t;
	localparam logic [31:0] PAT = 32'h5A5A5A5A;
	localparam logic [15:0] NONE = 16'hFFF0;
	// ----------------------------------------
	// stimulus and observed signals
	// ----------------------------------------
	logic clk_i = 1'h0, resetn_i = 1'h0, req_i = 1'h0, write_i = 1'h0, ws_cfg_wr_i = 1'h0;
	logic [31:0] addr_i = 32'h0, wdata_i = 32'h0, mem_rdata_i;
	logic [1:0] size_i = 2'h0;
	logic ramx_present_i = 1'h1, io0_present_i = 1'h1, redund_sel_i = 1'h0, ram_edac_i = 1'h0;
	logic io0_parity_i = 1'h1, external_halt_request_i = 1'h0, sw_halt_i = 1'h0;
	logic system_available_out_set_i = 1'h0, integer_unit_err_i = 1'h0, floating_point_unit_err_i = 1'h0;
	logic own_err_i = 1'h0, err_reset_mode_i = 1'h0;
	logic [2:0] err_mask_i = 3'h0;
	logic [3:0] ram_rd_ws_i = 4'h0, ram_wr_ws_i = 4'h0, prom_ws_i = 4'h1, io0_ws_i = 4'h1;
	logic ready_o, mexc_o, prom_sel_n_o, regs_sel_n_o, io0_sel_n_o, mem_rd_o, mem_wr_o;
	logic par_chk_o, edac_chk_o, freeze_o, error_reset_o, system_available_out_o;
	logic system_error_out_o, processor_halted_out_o;
	logic [31:0] rdata_o, boot_vector_o, mem_addr_o, mem_wdata_o;
	logic [8:0] memory_bank_select_n_o;
	logic [1:0] mem_size_o;
	int checks = 0, fail_count = 0, cyc = 0, t_take = 0;
	bmd_exp_t q[$];
	bmd_exp_t e;
	logic [31:0] ea [8] = '{32'h00080000, 32'h0, 32'h01F80000, 32'h10000200,
		32'h02000002, 32'h02000000, 32'h80000000, 32'h02200000};
	logic [2:0] ew [8] = '{3'h2, 3'h6, 3'h4, 3'h0, 3'h2, 3'h3, 3'h0, 3'h2};

	bmd_board_decode #(.WS_W(4)) DUT (.clk_i, .resetn_i, .req_i, .addr_i, .write_i, .size_i,
		.wdata_i, .ready_o, .mexc_o, .rdata_o, .boot_vector_o, .memory_bank_select_n_o,
		.prom_sel_n_o, .regs_sel_n_o, .io0_sel_n_o, .mem_addr_o, .mem_rd_o, .mem_wr_o,
		.mem_size_o, .mem_wdata_o, .par_chk_o, .edac_chk_o, .mem_rdata_i, .ramx_present_i,
		.io0_present_i, .redund_sel_i, .ram_edac_i, .io0_parity_i, .ws_cfg_wr_i, .ram_rd_ws_i,
		.ram_wr_ws_i, .prom_ws_i, .io0_ws_i, .external_halt_request_i, .sw_halt_i,
		.system_available_out_set_i, .integer_unit_err_i, .floating_point_unit_err_i, .own_err_i,
		.err_mask_i, .err_reset_mode_i, .freeze_o, .error_reset_o, .system_available_out_o,
		.system_error_out_o, .processor_halted_out_o);

	bmd_mem_model u_mem (.clk_i, .mem_rd_i(mem_rd_o), .mem_addr_i(mem_addr_o),
		.mem_rdata_o(mem_rdata_i));

	// clock and cycle count
	initial forever #25 clk_i = ~clk_i;
	always @(posedge clk_i) cyc <= cyc + 1;

	// ----------------------------------------
	// compare and bus tasks
	// ----------------------------------------
	task automatic cmp(input string nm, input logic [31:0] x, input logic [31:0] g);
		checks++;
		if (g !== x) begin
			fail_count++;
			$display("[FAIL] %s exp %h got %h", nm, x, g);
		end
	endtask : cmp

	task automatic cbit(input string nm, input logic x, input logic g);
		checks++;
		if (g !== x) begin
			fail_count++;
			$display("[FAIL] %s exp %b got %b", nm, x, g);
		end
	endtask : cbit

	function automatic logic [15:0] ev(input logic [8:0] b, input logic [2:0] o, input logic w,
		input logic p, input logic d);
		return {b, o, ~w, w, p, d};
	endfunction : ev

	// one access: note expectation, hold request to the take edge, check strobes in c1
	task automatic bus(input logic [31:0] a, input logic w, input logic [1:0] sz,
		input logic mx, input int lat, input logic [15:0] sv);
		logic [31:0] d;
		bmd_exp_t x;
		d = $urandom;
		x = '{mx, !w && !mx, a ^ PAT, lat};
		// prom word read: byte at a+i lands in lane 3-i
		if (!w && a < 32'h00080000 && sz == 2'h2) begin
			for (int i = 0; i < 4; i++) x.rd[31 - 8 * i -: 8] = 8'(a + i) ^ PAT[7:0];
		end
		@(posedge clk_i);
		req_i <= 1'h1;
		addr_i <= a;
		write_i <= w;
		size_i <= sz;
		wdata_i <= d;
		q.push_back(x);
		@(posedge clk_i);
		t_take = cyc;
		req_i <= 1'h0;
		@(negedge clk_i);
		cmp("strobes", {16'h0, sv}, {16'h0, memory_bank_select_n_o, prom_sel_n_o, regs_sel_n_o,
			io0_sel_n_o, mem_rd_o, mem_wr_o, par_chk_o, edac_chk_o});
		if (w && !mx) cmp("wdata", d, mem_wdata_o);
		if (!mx) cmp("mem addr", a, mem_addr_o);
		if (!mx) cmp("mem size", {30'h0, (a < 32'h00080000 ? 2'h0 : sz)},
			{30'h0, mem_size_o});
		for (int i = 0; i < 40 && q.size() > 0; i++) @(posedge clk_i);
		if (q.size() > 0) cmp("answer", 32'h1, 32'h0);
		q.delete();
	endtask : bus

	task automatic rst(input int n);
		@(posedge clk_i);
		resetn_i <= 1'h0;
		repeat (n) @(posedge clk_i);
		resetn_i <= 1'h1;
	endtask : rst

	task automatic wt(input int n);
		repeat (n) @(posedge clk_i);
		@(negedge clk_i);
	endtask : wt

	task automatic tdone(input string nm);
		$display("test %s done", nm);
	endtask : tdone

	task automatic summarize();
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : summarize

	// watcher: each answer consumes the oldest expectation
	always @(negedge clk_i) begin
		if (ready_o === 1'h1 || mexc_o === 1'h1) begin
			if (q.size() == 0) cmp("spurious answer", 32'h0, 32'h1);
			else begin
				e = q.pop_front();
				cbit("mexc", e.mx, mexc_o);
				if (e.ck) cmp("rdata", e.rd, rdata_o);
				if (e.lat > 0) cmp("latency", e.lat, cyc - t_take);
			end
		end
	end

	// hang guard
	initial begin
		repeat (20000) @(posedge clk_i);
		cmp("watchdog", 32'h1, 32'h0);
		summarize();
	end

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	initial begin
		logic [31:0] a;
		logic [2:0] m;
		void'($urandom(51057));
		rst(20);
		@(negedge clk_i);
		cmp("boot vector", 32'h0, boot_vector_o);
		bus(32'h00000100, 1'h0, 2'h2, 1'h0, 9, ev(9'h1FF, 3'h3, 1'h0, 1'h0, 1'h0));
		bus(32'h02000040, 1'h0, 2'h2, 1'h0, 2, ev(9'h1FE, 3'h7, 1'h0, 1'h1, 1'h0));
		bus(32'h021FFFFC, 1'h1, 2'h0, 1'h0, 2, ev(9'h1FE, 3'h7, 1'h1, 1'h1, 1'h0));
		bus(32'h02200000, 1'h0, 2'h1, 1'h0, 2, ev(9'h1FD, 3'h7, 1'h0, 1'h1, 1'h0));
		bus(32'h01F80010, 1'h0, 2'h0, 1'h0, 2, ev(9'h1FF, 3'h5, 1'h0, 1'h1, 1'h0));
		bus(32'h01F80010, 1'h1, 2'h2, 1'h0, 2, ev(9'h1FF, 3'h5, 1'h1, 1'h1, 1'h0));
		bus(32'h100001FC, 1'h0, 2'h2, 1'h0, 3, ev(9'h1FF, 3'h6, 1'h0, 1'h1, 1'h0));
		ram_edac_i <= 1'h1;
		redund_sel_i <= 1'h1;
		bus(32'h02000000, 1'h0, 2'h2, 1'h0, 2, ev(9'h0FF, 3'h7, 1'h0, 1'h0, 1'h1));
		redund_sel_i <= 1'h0;
		ramx_present_i <= 1'h0;
		tdone("decode");
		for (int i = 0; i < 8; i++) bus(ea[i], ew[i][2], ew[i][1:0], 1'h1, 1, NONE);
		ramx_present_i <= 1'h1;
		tdone("refusals");
		ram_rd_ws_i <= 4'h3;
		ws_cfg_wr_i <= 1'h1;
		@(posedge clk_i);
		ws_cfg_wr_i <= 1'h0;
		repeat (6) begin
			a = 32'h02000000 | ($urandom & 32'h001FFFFC);
			bus(a, 1'h1, 2'h2, 1'h0, 2, ev(9'h1FE, 3'h7, 1'h1, 1'h0, 1'h1));
			bus(a, 1'h0, 2'h2, 1'h0, 5, ev(9'h1FE, 3'h7, 1'h0, 1'h0, 1'h1));
		end
		rst(2);
		bus(32'h02000010, 1'h0, 2'h2, 1'h0, 2, ev(9'h1FE, 3'h7, 1'h0, 1'h0, 1'h1));
		tdone("wait states");
		wt(1);
		cbit("available", 1'h0, system_available_out_o);
		cbit("halted", 1'h0, processor_halted_out_o);
		system_available_out_set_i <= 1'h1;
		@(posedge clk_i);
		system_available_out_set_i <= 1'h0;
		wt(2);
		cbit("available", 1'h1, system_available_out_o);
		sw_halt_i <= 1'h1;
		wt(2);
		cbit("halted", 1'h1, processor_halted_out_o);
		cbit("available", 1'h0, system_available_out_o);
		sw_halt_i <= 1'h0;
		external_halt_request_i <= 1'h1;
		wt(5);
		cbit("freeze", 1'h1, freeze_o);
		cbit("halted", 1'h1, processor_halted_out_o);
		external_halt_request_i <= 1'h0;
		wt(5);
		cbit("freeze", 1'h0, freeze_o);
		cbit("available", 1'h1, system_available_out_o);
		tdone("halt");
		for (int k = 0; k < 3; k++) begin
			m = 3'h4 >> k;
			rst(2);
			err_mask_i <= m;
			{integer_unit_err_i, floating_point_unit_err_i, own_err_i} <= m;
			wt(3);
			cbit("error masked", 1'h0, system_error_out_o);
			err_mask_i <= 3'h7 ^ m;
			wt(2);
			cbit("error", 1'h1, system_error_out_o);
			cbit("error halt", 1'h1, processor_halted_out_o);
			{integer_unit_err_i, floating_point_unit_err_i, own_err_i} <= 3'h0;
		end
		rst(2);
		err_mask_i <= 3'h0;
		err_reset_mode_i <= 1'h1;
		own_err_i <= 1'h1;
		wt(3);
		cbit("error reset", 1'h1, error_reset_o);
		cbit("no halt", 1'h0, processor_halted_out_o);
		own_err_i <= 1'h0;
		tdone("errors");
		summarize();
	end
endmodule : tb_top
